// File: alarm_source.sv
// Purpose: Stands in for the reference sources, select pins and fault monitors.
// Assumes: Bench requests change just after a rising or a falling edge.
// Notes:   Outputs come from flip-flops, as a monitor's would.
`timescale 1ns/10ps
module alarm_source (
  input  wire logic       aclk,
  input  wire logic       zero_delay_on,
  input  wire logic [1:0] pin_req,
  input  wire logic [3:0] los_req,
  input  wire logic [3:0] oof_req,
  output logic      [1:0] select_pins,
  output logic      [3:0] signal_loss_alarm,
  output logic      [3:0] frequency_fault_alarm
);
  // Code 11 is never strapped while input 3 serves as feedback.
  always_ff @(posedge aclk) begin
    select_pins <= (zero_delay_on && pin_req == 2'h3) ? 2'h2 : pin_req;
  end
  // Alarm levels follow the commanded fault pattern.
  always_ff @(posedge aclk) begin
    signal_loss_alarm     <= los_req;
    frequency_fault_alarm <= oof_req;
  end
endmodule

// File: clock_select_pkg.sv
// Purpose: Shared constants and types for the reference input selector.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes:   Every offset, field position, field reset value and code lives here.
package clock_select_pkg;

  // Bus geometry.
  localparam int          ADDR_W          = 16;
  localparam int          IDX_W           = 14;

  // Register indices (byte address is index times four).
  localparam logic [13:0] IDX_ZERO_DELAY  = 14'h0487;
  localparam logic [13:0] IDX_SEL_CTRL    = 14'h052A;
  localparam logic [13:0] IDX_POLICY      = 14'h0536;
  localparam logic [13:0] IDX_MASKS       = 14'h0537;
  localparam logic [13:0] IDX_RANK01      = 14'h0538;
  localparam logic [13:0] IDX_RANK23      = 14'h0539;
  localparam logic [13:0] IDX_STATUS      = 14'h0540;

  // Field positions inside the low data byte.
  localparam int          ZD_EN_BIT       = 0;
  localparam int          ZD_CHOICE_LSB   = 1;
  localparam int          SRC_BIT         = 0;
  localparam int          CHOICE_LSB      = 1;
  localparam int          POLICY_LSB      = 0;
  localparam int          HITLESS_BIT     = 2;
  localparam int          LOS_MASK_LSB    = 0;
  localparam int          OOF_MASK_LSB    = 4;
  localparam int          RANK_EVEN_LSB   = 0;
  localparam int          RANK_ODD_LSB    = 4;
  localparam int          ST_ACTIVE_LSB   = 0;
  localparam int          ST_NO_VALID_BIT = 2;
  localparam int          ST_HITLESS_BIT  = 3;
  localparam int          ST_VALID_LSB    = 4;

  // Values after reset.
  localparam logic        RST_ZD_EN       = 1'b0;
  localparam logic [1:0]  RST_ZD_CHOICE   = 2'h0;
  localparam logic        RST_SOURCE      = 1'b0;
  localparam logic [1:0]  RST_CHOICE      = 2'h0;
  localparam logic [1:0]  RST_POLICY      = 2'h0;
  localparam logic        RST_HITLESS     = 1'b0;
  localparam logic [3:0]  RST_MASK        = 4'h0;
  localparam logic [2:0]  RST_RANK        = 3'h0;
  localparam logic [1:0]  RST_ACTIVE      = 2'h0;

  // Switching policy codes and other encodings.
  localparam logic [1:0]  POLICY_MANUAL   = 2'h0;
  localparam logic [1:0]  POLICY_NONREV   = 2'h1;
  localparam logic [1:0]  POLICY_REVERT   = 2'h2;
  localparam logic [1:0]  FEEDBACK_INDEX  = 2'h3;
  localparam logic [2:0]  RANK_NEVER      = 3'h0;
  localparam logic [2:0]  RANK_LOWEST     = 3'h4;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Effective selection behaviour after zero-delay and policy are combined.
  typedef enum logic [1:0] {SEL_MANUAL, SEL_NONREV, SEL_REVERT} sel_mode_t;

endpackage

// File: input_clock_selector.sv
// Purpose: Chooses the reference input for the PLL, manually or by rank, over AXI4-Lite.
// Assumes: Select pins and alarm inputs are synchronous to aclk.
// Notes:   Byte address of each register is four times its word index.
// Functional notes
// - Policy field: 00 manual, 01 automatic non-revertive, 02 automatic revertive.
// - In manual mode the source bit picks pins at 0, register at 1.
// - Manual choice field values 0 to 3 map to inputs 0 to 3.
// - Source bit resets to pin-driven selection.
// - Pin-driven selection maps pin codes 00 to 11 straight to inputs.
// - Zero-delay mode makes input 3 feedback, never a reference; pin code 11 reserved.
// - Zero-delay register selection uses its own choice field, inputs 0 to 2 only.
// - Zero-delay enable bit: 0 disables, 1 enables.
// - Manual mode with no clock on the chosen input sends the PLL to holdover.
// - Automatic mode ignores select pins and manual choice field.
// - Automatic mode considers only inputs without unmasked alarms.
// - Automatic mode with no valid input places the PLL in holdover.
// - Revertive mode always takes the best valid input, switching back at once.
// - Non-revertive mode keeps the active input while valid, else takes the best.
// - Zero-delay mode disables automatic selection and hitless switching.
// - Each input has a three-bit rank; 1 to 4 rank it, 0 never selected.
// - Signal-loss mask bit 0 lets the alarm count; 1 ignores it.
// - Frequency-fault mask bit 0 lets the alarm count; 1 ignores it.
// - Zero-delay with register selection ignores the ordinary manual choice field.
// - Pin-driven source ignores the manual choice field, also in zero-delay mode.
`timescale 1ns/10ps
module input_clock_selector (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  select_pins,
  input  wire logic [3:0]  signal_loss_alarm,
  input  wire logic [3:0]  frequency_fault_alarm,
  output logic [1:0]       selected_input,
  output logic             no_valid_input,
  output logic             feedback_mode,
  output logic             hitless_active
);

  // Software-visible fields.
  logic                          zero_delay_enable;
  logic [1:0]                    zero_delay_input_choice;
  logic                          selection_source_reg;
  logic [1:0]                    manual_input_choice;
  logic [1:0]                    switch_policy_select;
  logic                          hitless_enable;
  logic [3:0]                    signal_loss_ignore_mask;
  logic [3:0]                    freq_fault_ignore_mask;
  logic [2:0]                    input0_rank;
  logic [2:0]                    input1_rank;
  logic [2:0]                    input2_rank;
  logic [2:0]                    input3_rank;

  // Bus holding state.
  logic                          aw_held;
  logic                          w_held;
  logic [15:0]                   aw_addr;
  logic [31:0]                   w_data;
  logic [3:0]                    w_strb;
  logic                          wr_fire;

  // Selection state.
  clock_select_pkg::sel_mode_t   sel_mode;
  logic [3:0]                    input_valid;
  logic [11:0]                   rank_vec;
  logic [1:0]                    best_index;
  logic                          any_valid;
  logic [1:0]                    manual_pick;
  logic                          manual_bad;
  logic [1:0]                    next_selected;
  logic                          next_no_valid;

  // Word index of a byte address; used by both the write and the read path.
  function automatic logic [13:0] addr_index(input logic [15:0] addr);
    addr_index = addr[15:2];
  endfunction

  // True for any index that holds a register.
  function automatic logic addr_mapped(input logic [13:0] idx);
    addr_mapped = (idx == clock_select_pkg::IDX_ZERO_DELAY) ||
                  (idx == clock_select_pkg::IDX_SEL_CTRL) ||
                  (idx == clock_select_pkg::IDX_POLICY) ||
                  (idx == clock_select_pkg::IDX_MASKS) ||
                  (idx == clock_select_pkg::IDX_RANK01) ||
                  (idx == clock_select_pkg::IDX_RANK23) ||
                  (idx == clock_select_pkg::IDX_STATUS);
  endfunction

  // Address and data are accepted independently and held until the response goes out.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write address capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 16'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write response; an unmapped address answers with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= clock_select_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(addr_index(aw_addr)) ? clock_select_pkg::RESP_OKAY
                                                       : clock_select_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register update; only byte lane 0 carries fields, the status word is read-only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_delay_enable       <= clock_select_pkg::RST_ZD_EN;
      zero_delay_input_choice <= clock_select_pkg::RST_ZD_CHOICE;
      selection_source_reg    <= clock_select_pkg::RST_SOURCE;
      manual_input_choice     <= clock_select_pkg::RST_CHOICE;
      switch_policy_select    <= clock_select_pkg::RST_POLICY;
      hitless_enable          <= clock_select_pkg::RST_HITLESS;
      signal_loss_ignore_mask <= clock_select_pkg::RST_MASK;
      freq_fault_ignore_mask  <= clock_select_pkg::RST_MASK;
      input0_rank             <= clock_select_pkg::RST_RANK;
      input1_rank             <= clock_select_pkg::RST_RANK;
      input2_rank             <= clock_select_pkg::RST_RANK;
      input3_rank             <= clock_select_pkg::RST_RANK;
    end else if (wr_fire && w_strb[0]) begin
      case (addr_index(aw_addr))
        clock_select_pkg::IDX_ZERO_DELAY: begin
          zero_delay_enable       <= w_data[clock_select_pkg::ZD_EN_BIT];
          zero_delay_input_choice <= w_data[clock_select_pkg::ZD_CHOICE_LSB +: 2];
        end
        clock_select_pkg::IDX_SEL_CTRL: begin
          selection_source_reg <= w_data[clock_select_pkg::SRC_BIT];
          manual_input_choice  <= w_data[clock_select_pkg::CHOICE_LSB +: 2];
        end
        clock_select_pkg::IDX_POLICY: begin
          switch_policy_select <= w_data[clock_select_pkg::POLICY_LSB +: 2];
          hitless_enable       <= w_data[clock_select_pkg::HITLESS_BIT];
        end
        clock_select_pkg::IDX_MASKS: begin
          signal_loss_ignore_mask <= w_data[clock_select_pkg::LOS_MASK_LSB +: 4];
          freq_fault_ignore_mask  <= w_data[clock_select_pkg::OOF_MASK_LSB +: 4];
        end
        clock_select_pkg::IDX_RANK01: begin
          input0_rank <= w_data[clock_select_pkg::RANK_EVEN_LSB +: 3];
          input1_rank <= w_data[clock_select_pkg::RANK_ODD_LSB +: 3];
        end
        clock_select_pkg::IDX_RANK23: begin
          input2_rank <= w_data[clock_select_pkg::RANK_EVEN_LSB +: 3];
          input3_rank <= w_data[clock_select_pkg::RANK_ODD_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
  end

  // Read path: one cycle to the answer, reserved bits read as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= clock_select_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_mapped(addr_index(s_axi_araddr)) ? clock_select_pkg::RESP_OKAY
                                                            : clock_select_pkg::RESP_SLVERR;
      case (addr_index(s_axi_araddr))
        clock_select_pkg::IDX_ZERO_DELAY:
          s_axi_rdata <= {29'h0, zero_delay_input_choice, zero_delay_enable};
        clock_select_pkg::IDX_SEL_CTRL:
          s_axi_rdata <= {29'h0, manual_input_choice, selection_source_reg};
        clock_select_pkg::IDX_POLICY:
          s_axi_rdata <= {29'h0, hitless_enable, switch_policy_select};
        clock_select_pkg::IDX_MASKS:
          s_axi_rdata <= {24'h0, freq_fault_ignore_mask, signal_loss_ignore_mask};
        clock_select_pkg::IDX_RANK01:
          s_axi_rdata <= {25'h0, input1_rank, 1'b0, input0_rank};
        clock_select_pkg::IDX_RANK23:
          s_axi_rdata <= {25'h0, input3_rank, 1'b0, input2_rank};
        clock_select_pkg::IDX_STATUS:
          s_axi_rdata <= {24'h0, input_valid, hitless_active, no_valid_input, selected_input};
        default:
          s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Effective mode; zero-delay and the reserved policy code fall back to manual.
  always_comb begin
    if (zero_delay_enable) begin
      sel_mode = clock_select_pkg::SEL_MANUAL;
    end else begin
      case (switch_policy_select)
        clock_select_pkg::POLICY_NONREV: sel_mode = clock_select_pkg::SEL_NONREV;
        clock_select_pkg::POLICY_REVERT: sel_mode = clock_select_pkg::SEL_REVERT;
        default:                         sel_mode = clock_select_pkg::SEL_MANUAL;
      endcase
    end
  end

  // Validity per input: unmasked alarms disqualify, ranks 0 and above 4 never qualify.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_valid
      logic [2:0] rank_i;
      assign rank_i = rank_vec[i*3 +: 3];
      assign input_valid[i] = !(signal_loss_alarm[i] && !signal_loss_ignore_mask[i]) &&
                              !(frequency_fault_alarm[i] && !freq_fault_ignore_mask[i]) &&
                              (rank_i != clock_select_pkg::RANK_NEVER) &&
                              (rank_i <= clock_select_pkg::RANK_LOWEST);
    end
  endgenerate

  assign rank_vec = {input3_rank, input2_rank, input1_rank, input0_rank};

  // Best ranked valid input.
  rank_picker u_rank_picker (
    .eligible     (input_valid),
    .ranks        (rank_vec),
    .best_index   (best_index),
    .any_eligible (any_valid)
  );

  // Manual pick: pins when the source bit is low, else the zero-delay or ordinary field.
  always_comb begin
    if (!selection_source_reg) begin
      manual_pick = select_pins;
    end else if (zero_delay_enable) begin
      manual_pick = zero_delay_input_choice;
    end else begin
      manual_pick = manual_input_choice;
    end
    manual_bad = signal_loss_alarm[manual_pick] ||
                 (zero_delay_enable && (manual_pick == clock_select_pkg::FEEDBACK_INDEX));
  end

  // Next chosen input and holdover request.
  always_comb begin
    next_selected = selected_input;
    next_no_valid = no_valid_input;
    case (sel_mode)
      clock_select_pkg::SEL_MANUAL: begin
        next_no_valid = manual_bad;
        if (!(zero_delay_enable && (manual_pick == clock_select_pkg::FEEDBACK_INDEX))) begin
          next_selected = manual_pick;
        end
      end
      clock_select_pkg::SEL_NONREV: begin
        if (!(input_valid[selected_input] && !no_valid_input)) begin
          next_selected = any_valid ? best_index : selected_input;
          next_no_valid = !any_valid;
        end
      end
      clock_select_pkg::SEL_REVERT: begin
        next_selected = any_valid ? best_index : selected_input;
        next_no_valid = !any_valid;
      end
      default: begin
        next_no_valid = 1'b1;
      end
    endcase
  end

  // Outputs to PLL control, all registered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selected_input <= clock_select_pkg::RST_ACTIVE;
      no_valid_input <= 1'b1;
      feedback_mode  <= 1'b0;
      hitless_active <= 1'b0;
    end else begin
      selected_input <= next_selected;
      no_valid_input <= next_no_valid;
      feedback_mode  <= zero_delay_enable;
      hitless_active <= hitless_enable && !zero_delay_enable;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pin_manual;
    (sel_mode == clock_select_pkg::SEL_MANUAL) && !selection_source_reg && !zero_delay_enable;
  endsequence

  sequence s_reg_manual;
    (sel_mode == clock_select_pkg::SEL_MANUAL) && selection_source_reg;
  endsequence

  a_pin_select_path: assert property (s_pin_manual |=> selected_input == $past(select_pins))
    else $error("pin selection not followed");
  a_reg_choice_path: assert property ((s_reg_manual and !zero_delay_enable) |=>
      selected_input == $past(manual_input_choice))
    else $error("register choice not followed");
  a_zd_choice_path: assert property ((s_reg_manual and zero_delay_enable &&
      zero_delay_input_choice != clock_select_pkg::FEEDBACK_INDEX) |=>
      selected_input == $past(zero_delay_input_choice) && feedback_mode)
    else $error("zero-delay choice not followed");
  a_zd_feedback_out: assert property ((zero_delay_enable ##1 zero_delay_enable) |->
      (selected_input != clock_select_pkg::FEEDBACK_INDEX) || no_valid_input)
    else $error("feedback input used as reference");
  a_manual_no_clock: assert property ((s_pin_manual and signal_loss_alarm[select_pins]) |=>
      no_valid_input)
    else $error("manual loss did not enter holdover");
  a_auto_holdover: assert property ((sel_mode != clock_select_pkg::SEL_MANUAL &&
      input_valid == 4'h0) |=> no_valid_input)
    else $error("no valid input without holdover");
  a_revert_best: assert property ((sel_mode == clock_select_pkg::SEL_REVERT && any_valid) |=>
      selected_input == $past(best_index) && !no_valid_input)
    else $error("revertive mode missed best input");
  a_nonrev_keep: assert property ((sel_mode == clock_select_pkg::SEL_NONREV &&
      input_valid[selected_input] && !no_valid_input) |=> $stable(selected_input))
    else $error("non-revertive mode left a valid input");
  a_mask_validity: assert property ((input_valid & ((signal_loss_alarm & ~signal_loss_ignore_mask) |
      (frequency_fault_alarm & ~freq_fault_ignore_mask))) == 4'h0)
    else $error("unmasked alarm left input valid");
  a_zd_no_hitless: assert property (zero_delay_enable |=> !hitless_active)
    else $error("hitless switching active in zero-delay mode");
  a_source_default: assert property ($rose(aresetn) |-> !selection_source_reg)
    else $error("source bit not pin-driven after reset");

endmodule

// File: rank_picker.sv
// Purpose: Finds the best ranked valid input among the four reference inputs.
// Assumes: Rank 1 is the highest; rank 0 and ranks above the lowest never win.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module rank_picker (
  input  wire logic [3:0]  eligible,
  input  wire logic [11:0] ranks,
  output logic      [1:0]  best_index,
  output logic             any_eligible
);

  logic [2:0] best_rank;

  // Strict comparison keeps the lower index on equal ranks.
  always_comb begin
    best_index   = 2'h0;
    best_rank    = 3'h7;
    any_eligible = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (eligible[i] && (!any_eligible || (ranks[i*3 +: 3] < best_rank))) begin
        best_index   = i[1:0];
        best_rank    = ranks[i*3 +: 3];
        any_eligible = 1'b1;
      end
    end
  end

endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the reference input selector.
// Assumes: Alarms and pins reach the design through alarm_source.
// Notes:   Shadow registers feed a model that predicts every selection.
`timescale 1ns/10ps
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val, rnd;
  logic [3:0]  s_axi_wstrb = 4'hF, los_req = 4'h0, oof_req = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, no_valid_input, feedback_mode;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, select_pins, selected_input, rd_resp;
  logic [1:0]  pin_req = 2'h0;
  logic [3:0]  signal_loss_alarm, frequency_fault_alarm, e_v;
  logic        hitless_active;
  logic [7:0]  sh_zd = 8'h0, sh_sc = 8'h0, sh_pol = 8'h0, sh_msk = 8'h0, sh_r01 = 8'h0;
  logic [7:0]  sh_r23 = 8'h0;
  int          n_fail = 0, n_tests = 0, seed = 32'hdb62, e_sel = 0, e_nv = 1, i;
  // Free-running 25 MHz clock.
  always #20 aclk = ~aclk;
  input_clock_selector input_clock_selector_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .select_pins, .signal_loss_alarm, .frequency_fault_alarm,
    .selected_input, .no_valid_input, .feedback_mode, .hitless_active);
  alarm_source alarm_source_inst (.aclk, .zero_delay_on(sh_zd[0]), .pin_req, .los_req,
    .oof_req, .select_pins, .signal_loss_alarm, .frequency_fault_alarm);
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("Counts: %0d compared, %0d failed", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Steps the selection model once on settled inputs.
  task automatic model;
    int p, best, r;
    logic [3:0] v;
    logic [15:0] rk;
    best = -1;
    r = 9;
    rk = {sh_r23, sh_r01};
    for (int j = 0; j < 4; j++) begin
      v[j] = !(signal_loss_alarm[j] && !sh_msk[j]) && !(frequency_fault_alarm[j] && !sh_msk[4 + j])
             && rk[4*j +: 3] >= 3'h1 && rk[4*j +: 3] <= 3'h4;
      if (v[j] && rk[4*j +: 3] < r) begin
        r = rk[4*j +: 3];
        best = j;
      end
    end
    if (sh_zd[0] || sh_pol[1:0] == 2'h0 || sh_pol[1:0] == 2'h3) begin
      p = !sh_sc[0] ? select_pins : (sh_zd[0] ? sh_zd[2:1] : sh_sc[2:1]);
      e_nv = signal_loss_alarm[p] || (sh_zd[0] && p == 3);
      if (!(sh_zd[0] && p == 3)) e_sel = p;
    end else if (!(sh_pol[1:0] == 2'h1 && v[e_sel] && !e_nv)) begin
      e_nv = best < 0;
      if (best >= 0) e_sel = best;
    end
    e_v = v;
  endtask
  // Lets the inputs settle, then checks every selection output.
  task automatic sync_chk;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    model();
    chk(selected_input, e_sel[1:0]);
    chk(no_valid_input, e_nv[0]);
    chk(feedback_mode, sh_zd[0]);
    chk(hitless_active, sh_pol[2] && !sh_zd[0]);
  endtask
  // One AXI4-Lite write; the shadow follows an accepted write.
  task automatic wr(input logic [13:0] ix, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, b;
    int n;
    @(posedge aclk);
    rnd = $random(seed);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b) chk(s_axi_bresp, er);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    if (n == 40) begin
      n_fail++;
      tally_and_finish();
    end
    s_axi_bready <= 1'b0;
    case (ix)
      clock_select_pkg::IDX_ZERO_DELAY: sh_zd = d & 8'h07;
      clock_select_pkg::IDX_SEL_CTRL: sh_sc = d & 8'h07;
      clock_select_pkg::IDX_POLICY: sh_pol = d & 8'h07;
      clock_select_pkg::IDX_MASKS: sh_msk = d;
      clock_select_pkg::IDX_RANK01: sh_r01 = d & 8'h77;
      clock_select_pkg::IDX_RANK23: sh_r23 = d & 8'h77;
      default: ;
    endcase
    sync_chk();
  endtask
  // One AXI4-Lite read into rd_val and rd_resp.
  task automatic rd(input logic [13:0] ix);
    logic ta, rv;
    int n;
    @(posedge aclk);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rd_val = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (rv) break;
    end
    if (n == 40) begin
      n_fail++;
      tally_and_finish();
    end
    s_axi_rready <= 1'b0;
  endtask
  // Main sequence: reset, manual, zero-delay, randomised runs over manual, non-revertive and revertive policy, then a second reset.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    sync_chk();
    rd(clock_select_pkg::IDX_SEL_CTRL);
    chk(rd_val, 32'h0);
    rd(14'h0100);
    chk(rd_resp, clock_select_pkg::RESP_SLVERR);
    wr(14'h0100, 8'hFF, clock_select_pkg::RESP_SLVERR);
    wr(clock_select_pkg::IDX_SEL_CTRL, 8'h04, 2'h0);
    for (i = 0; i < 4; i++) begin
      pin_req <= 2'(i);
      los_req <= 4'($random(seed));
      sync_chk();
    end
    for (i = 0; i < 4; i++) begin
      los_req <= 4'($random(seed));
      wr(clock_select_pkg::IDX_SEL_CTRL, 8'(2 * i + 1), 2'h0);
    end
    // Pin code 11 is parked before input 3 turns into the feedback input.
    pin_req <= 2'h0;
    for (i = 0; i < 3; i++) begin
      wr(clock_select_pkg::IDX_ZERO_DELAY, 8'(2 * i + 1), 2'h0);
    end
    wr(clock_select_pkg::IDX_POLICY, 8'h06, 2'h0);
    wr(clock_select_pkg::IDX_SEL_CTRL, 8'h06, 2'h0);
    for (i = 0; i < 4; i++) begin
      pin_req <= 2'(i);
      sync_chk();
    end
    wr(clock_select_pkg::IDX_ZERO_DELAY, 8'h00, 2'h0);
    for (i = 0; i < 48; i++) begin
      pin_req <= 2'($random(seed));
      los_req <= 4'($random(seed));
      oof_req <= 4'($random(seed));
      // New alarms settle under the old settings first, so non-revertive history matches.
      sync_chk();
      wr(clock_select_pkg::IDX_MASKS, 8'($random(seed)), 2'h0);
      wr(clock_select_pkg::IDX_RANK01, 8'($random(seed)), 2'h0);
      wr(clock_select_pkg::IDX_RANK23, 8'($random(seed)), 2'h0);
      wr(clock_select_pkg::IDX_POLICY, 8'(i % 3), 2'h0);
      los_req <= 4'($random(seed));
      sync_chk();
      rd(clock_select_pkg::IDX_RANK23);
      chk(rd_val, {24'h0, sh_r23});
      chk(rd_resp, clock_select_pkg::RESP_OKAY);
      rd(clock_select_pkg::IDX_STATUS);
      chk(rd_val, {24'h0, e_v, sh_pol[2] && !sh_zd[0], e_nv[0], e_sel[1:0]});
    end
    // Second reset after the source bit was set; it must come back pin-driven.
    wr(clock_select_pkg::IDX_SEL_CTRL, 8'h03, 2'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    {sh_zd, sh_sc, sh_pol, sh_msk, sh_r01, sh_r23} = 48'h0;
    rd(clock_select_pkg::IDX_SEL_CTRL);
    chk(rd_val, 32'h0);
    sync_chk();
    tally_and_finish();
  end
endmodule
